// *** rtl/dbg_link_cfg.svh ***
/*
 * Timing and field constants of the single-wire debug bit link.
 * Assumes all counts are in debug clock ticks, not in system clocks.
 */
`ifndef DBG_LINK_CFG_SVH
`define DBG_LINK_CFG_SVH

// ----------------------------------------------------------------
// Bit timing, in debug clock ticks from the perceived bit start
// ----------------------------------------------------------------
`define BIT_LAST_TICK 8'd15
`define SAMPLE_TICK 8'd10
`define ZERO_LOW_TICKS 8'd13
`define ONE_SPEEDUP_TICK 8'd7
`define BYTE_LAST_BIT 3'd7

// ----------------------------------------------------------------
// Inactivity timeout and rate reference pulse
// ----------------------------------------------------------------
`define TIMEOUT_LAST 10'd511
`define SYNC_LOW_TICKS 8'd128
`define SYNC_GAP_TICKS 8'd16
`define SYNC_PULSE_TICKS 8'd128

// ----------------------------------------------------------------
// Command classes: codes that may run while the program runs
// ----------------------------------------------------------------
`define CMD_CLASS_MSB 2'b11
`define CMD_HALT_REQ 8'h90
`define CMD_ACK_ON 8'hd5
`define CMD_ACK_OFF 8'hd6

`endif

// *** rtl/dbg_link_pkg.sv ***
/*
 * Types shared by the debug bit link and its byte buffer.
 * Assumes the constants header is included by the users as well.
 */
package dbg_link_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HOST_BIT = 3'b001,
        ST_TGT_BIT = 3'b010,
        ST_SYNC_LOW = 3'b011,
        ST_SYNC_GAP = 3'b100,
        ST_SYNC_PULSE = 3'b101
    } link_state_t;
endpackage

// *** rtl/byte_buffer.sv ***
/*
 * Two-entry byte buffer with valid and ready on both sides.
 * Assumes one clock; flush empties it in one cycle and wins over a push.
 */
`timescale 1ns/1ps
module byte_buffer (
    // Clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic flush_in,
    // Filling side
    input wire dbg_link_pkg::byte_t in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // Draining side
    output dbg_link_pkg::byte_t out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    import dbg_link_pkg::*;

    byte_t mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic next_wr_ptr;
    logic next_rd_ptr;
    logic [1:0] next_count;
    logic push;
    logic pop;

    // Full and empty come straight from the count, so they never lie.
    assign in_ready_out = (count != 2'd2);
    assign out_valid_out = (count != 2'd0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Pointer and count update.
    always_comb begin
        next_wr_ptr = wr_ptr ^ push;
        next_rd_ptr = rd_ptr ^ pop;
        next_count = count + {1'b0, push} - {1'b0, pop};
        if (flush_in) begin
            next_wr_ptr = 1'b0;
            next_rd_ptr = 1'b0;
            next_count = 2'd0;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
            mem[0] <= 8'h00;
            mem[1] <= 8'h00;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            if (push) begin
                mem[wr_ptr] <= in_data_in;
            end
        end
    end
endmodule // byte_buffer

// *** rtl/debug_wire_link.sv ***
/*
 * Bit-level engine of the single-wire debug link, device side.
 * Assumes pin input is synchronous to CLOCK_IN and that the debug clock
 * is the system clock or a one-cycle tick from an alternate divider.
 */
`timescale 1ns/1ps
`include "dbg_link_cfg.svh"

module debug_wire_link (
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RESETN_IN,
    // Debug clock choice and alternate tick
    input wire logic DBG_CLK_SEL_IN,
    input wire logic ALT_TICK_IN,
    // Debug pin
    input wire logic PIN_IN,
    output logic PIN_OUT_OUT,
    output logic PIN_OE_OUT,
    // Received bytes toward the command decoder
    output dbg_link_pkg::byte_t RX_DATA_OUT,
    output logic RX_VALID_OUT,
    output logic RX_CMD_OUT,
    // Bytes to send back to the host
    input wire dbg_link_pkg::byte_t TX_DATA_IN,
    input wire logic TX_VALID_IN,
    output logic TX_READY_OUT,
    // Command framing and status
    input wire logic HALTED_IN,
    input wire logic CMD_DONE_IN,
    output logic CMD_REJECT_OUT,
    output logic ABORT_OUT,
    output logic SYNC_DONE_OUT,
    output logic BOOT_HALT_OUT
);
    import dbg_link_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    link_state_t state, next_state;
    logic [7:0] cnt, next_cnt;
    byte_t shreg, next_shreg;
    logic [2:0] bit_idx, next_bit_idx;
    logic tx_mode, next_tx_mode;
    logic cmd_expect, next_cmd_expect;
    logic [9:0] idle_cnt, next_idle_cnt;
    byte_t rx_data, next_rx_data;
    logic rx_valid, next_rx_valid, rx_cmd, next_rx_cmd;
    logic reject, next_reject, abort, next_abort, sync_done, next_sync_done;
    logic pin_out, pin_oe, next_pin_out, next_pin_oe;
    logic boot_taken, boot_halt, next_boot_taken, next_boot_halt;
    logic s1, s2, s3;
    logic dtick, fall, busy, pop;
    byte_t buf_data;
    logic buf_valid;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Non-intrusive codes may run at any time; all others need a halted CPU.
    function automatic logic cmd_allowed(input byte_t code, input logic halted);
        cmd_allowed = halted || (code[7:6] == `CMD_CLASS_MSB) ||
                      (code == `CMD_HALT_REQ) || (code == `CMD_ACK_ON) ||
                      (code == `CMD_ACK_OFF);
    endfunction

    // Pin drive for a state and tick: {enable, level}.
    function automatic logic [1:0] drive(input link_state_t st, input logic [7:0] c,
                                         input logic b);
        drive = 2'b00;
        if (st == ST_TGT_BIT) begin
            if (!b && c < `ZERO_LOW_TICKS) drive = 2'b10;
            else if (!b && c == `ZERO_LOW_TICKS) drive = 2'b11;
            else if (b && c == `ONE_SPEEDUP_TICK) drive = 2'b11;
        end else if (st == ST_SYNC_PULSE) begin
            drive = (c < `SYNC_PULSE_TICKS) ? 2'b10 : 2'b11;
        end
    endfunction

    // ----------------------------------------------------------------
    // Debug clock tick and pin synchroniser
    // ----------------------------------------------------------------
    // The debug clock is a tick enable, so the link stays in one clock domain.
    assign dtick = DBG_CLK_SEL_IN ? ALT_TICK_IN : 1'b1;
    // Only s2 and s3 feed the edge detector; s1 stays a pure first stage.
    assign fall = dtick && s3 && !s2;
    assign busy = (bit_idx != 3'd0) || tx_mode || !cmd_expect;
    assign pop = (state == ST_IDLE) && fall && (bit_idx == 3'd0) && buf_valid;

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else if (dtick) begin
            s1 <= PIN_IN;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ----------------------------------------------------------------
    // Bit engine next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_bit_idx = bit_idx;
        next_tx_mode = tx_mode;
        next_cmd_expect = cmd_expect || CMD_DONE_IN;
        next_idle_cnt = idle_cnt;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        next_rx_cmd = rx_cmd;
        next_reject = 1'b0;
        next_abort = 1'b0;
        next_sync_done = 1'b0;
        next_boot_taken = 1'b1;
        // The strap is caught on the first edge after release, never by reset.
        next_boot_halt = boot_taken ? boot_halt : !PIN_IN;
        if (dtick) begin
            // Idle counter restarts on every falling edge of the pin and saturates.
            if (fall) next_idle_cnt = 10'd0;
            else if (idle_cnt != `TIMEOUT_LAST) next_idle_cnt = idle_cnt + 10'd1;
            if (state != ST_IDLE) next_cnt = cnt + 8'd1;
            case (state)
                ST_IDLE: begin
                    if (fall) begin
                        next_cnt = 8'd0;
                        if (pop) begin
                            next_shreg = buf_data;
                            next_tx_mode = 1'b1;
                        end
                        next_state = (pop || tx_mode) ? ST_TGT_BIT : ST_HOST_BIT;
                    end
                end
                ST_HOST_BIT: begin
                    if (cnt == `SAMPLE_TICK) begin
                        next_shreg = {shreg[6:0], s2};
                    end
                    if (cnt == `BIT_LAST_TICK) begin
                        next_state = ST_IDLE;
                        // A line still low at bit end is a rate request.
                        if (!s2) next_state = ST_SYNC_LOW;
                        else begin
                            next_bit_idx = bit_idx + 3'd1;
                            if (bit_idx == `BYTE_LAST_BIT) begin
                                next_rx_data = shreg;
                                next_rx_cmd = cmd_expect;
                                next_cmd_expect = 1'b0;
                                if (cmd_expect && !cmd_allowed(shreg, HALTED_IN)) begin
                                    next_reject = 1'b1;
                                    next_cmd_expect = 1'b1;
                                end else begin
                                    next_rx_valid = 1'b1;
                                end
                            end
                        end
                    end
                end
                ST_TGT_BIT: begin
                    if (cnt == `BIT_LAST_TICK) begin
                        next_state = ST_IDLE;
                        next_shreg = {shreg[6:0], 1'b0};
                        next_bit_idx = bit_idx + 3'd1;
                        if (bit_idx == `BYTE_LAST_BIT) next_tx_mode = 1'b0;
                    end
                end
                ST_SYNC_LOW: begin
                    if (s2) begin
                        next_cnt = 8'd0;
                        next_state = (cnt >= `SYNC_LOW_TICKS) ? ST_SYNC_GAP : ST_IDLE;
                        next_bit_idx = 3'd0;
                        next_tx_mode = 1'b0;
                        next_cmd_expect = 1'b1;
                    end else if (cnt == 8'hff) begin
                        next_cnt = cnt; // hold once long enough
                    end
                end
                ST_SYNC_GAP: begin
                    if (cnt == `SYNC_GAP_TICKS) begin
                        next_cnt = 8'd0;
                        next_state = ST_SYNC_PULSE;
                    end
                end
                ST_SYNC_PULSE: begin
                    if (cnt == `SYNC_PULSE_TICKS) begin
                        next_state = ST_IDLE;
                        next_sync_done = 1'b1;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
            // Timeout drops link state and tx_mode; the abort pulse also flushes the reply buffer.
            if (!fall && idle_cnt == `TIMEOUT_LAST - 10'd1 && busy) begin
                next_abort = 1'b1;
                next_bit_idx = 3'd0;
                next_tx_mode = 1'b0;
                next_cmd_expect = 1'b1;
                next_state = ST_IDLE;
            end
        end
        {next_pin_oe, next_pin_out} = drive(next_state, next_cnt, next_shreg[7]);
    end

    // Pin drive is registered from next values so it lines up with the state.
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state <= ST_IDLE;
            cnt <= 8'd0;
            shreg <= 8'h00;
            bit_idx <= 3'd0;
            tx_mode <= 1'b0;
            cmd_expect <= 1'b1;
            idle_cnt <= 10'd0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_cmd <= 1'b0;
            reject <= 1'b0;
            abort <= 1'b0;
            sync_done <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            boot_taken <= 1'b0;
            boot_halt <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            bit_idx <= next_bit_idx;
            tx_mode <= next_tx_mode;
            cmd_expect <= next_cmd_expect;
            idle_cnt <= next_idle_cnt;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            rx_cmd <= next_rx_cmd;
            reject <= next_reject;
            abort <= next_abort;
            sync_done <= next_sync_done;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            boot_taken <= next_boot_taken;
            boot_halt <= next_boot_halt;
        end
    end

    // ----------------------------------------------------------------
    // Reply buffer and outputs
    // ----------------------------------------------------------------
    // The buffer drains only at a byte boundary, so the source really stalls.
    byte_buffer reply_buf (
        .clock_in(CLOCK_IN),
        .resetn_in(RESETN_IN),
        .flush_in(abort),
        .in_data_in(TX_DATA_IN),
        .in_valid_in(TX_VALID_IN),
        .in_ready_out(TX_READY_OUT),
        .out_data_out(buf_data),
        .out_valid_out(buf_valid),
        .out_ready_in(pop)
    );

    assign PIN_OUT_OUT = pin_out;
    assign PIN_OE_OUT = pin_oe;
    assign RX_DATA_OUT = rx_data;
    assign RX_VALID_OUT = rx_valid;
    assign RX_CMD_OUT = rx_cmd;
    assign CMD_REJECT_OUT = reject;
    assign ABORT_OUT = abort;
    assign SYNC_DONE_OUT = sync_done;
    assign BOOT_HALT_OUT = boot_halt;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);

    host_hands_off_a: assert property ((state == ST_HOST_BIT) |-> !PIN_OE_OUT)
        else $error("pin driven during a host bit");
    zero_low_a: assert property ((state == ST_TGT_BIT && !shreg[7] && cnt < `ZERO_LOW_TICKS)
        |-> (PIN_OE_OUT && !PIN_OUT_OUT))
        else $error("zero bit not held low");
    one_speedup_a: assert property ((state == ST_TGT_BIT && shreg[7])
        |-> (PIN_OE_OUT == (cnt == `ONE_SPEEDUP_TICK)))
        else $error("one bit speedup misplaced");
    bit_length_a: assert property ((state == ST_HOST_BIT || state == ST_TGT_BIT)
        |-> cnt <= `BIT_LAST_TICK)
        else $error("bit longer than sixteen ticks");
    host_sample_a: assert property ((state == ST_HOST_BIT && cnt == `SAMPLE_TICK && dtick)
        |=> shreg[0] == $past(s2))
        else $error("host bit sampled wrongly");
    timeout_abort_a: assert property ((dtick && !fall && busy
        && idle_cnt == `TIMEOUT_LAST - 10'd1)
        |=> (ABORT_OUT && state == ST_IDLE && bit_idx == 3'd0))
        else $error("timeout did not abort");
    clock_select_a: assert property (!DBG_CLK_SEL_IN |-> dtick)
        else $error("bus clock tick missing");
    sync_pulse_a: assert property ($rose(state == ST_SYNC_PULSE)
        |-> (PIN_OE_OUT && !PIN_OUT_OUT)[*8])
        else $error("reference pulse not driven low");
    boot_strap_a: assert property ($rose(boot_taken) |-> BOOT_HALT_OUT == !$past(PIN_IN))
        else $error("boot strap not captured");
    reject_a: assert property ((dtick && state == ST_HOST_BIT && cnt == `BIT_LAST_TICK && s2
        && bit_idx == `BYTE_LAST_BIT && cmd_expect && !HALTED_IN && shreg[7:6] == 2'b00)
        |=> (CMD_REJECT_OUT && !RX_VALID_OUT))
        else $error("halt-only command not refused");

    host_byte_c: cover property (RX_VALID_OUT && RX_CMD_OUT);
    target_byte_c: cover property (tx_mode && bit_idx == 3'd7 && state == ST_TGT_BIT);
    sync_c: cover property (SYNC_DONE_OUT);
    timeout_c: cover property (ABORT_OUT);
endmodule // debug_wire_link

// *** verification/host_pod.sv ***
/*
 * Behavioural debug pod: starts every bit, sends bytes, reads bytes back
 * and asks for the rate reference pulse.
 * Assumes the bench resolves the wire from both drivers and a pull-up.
 */
`timescale 1ns/1ps
module host_pod (
    // Clock and observed wire
    input wire logic clock_in,
    input wire logic wire_in,
    input wire logic dev_oe_in,
    input wire logic dev_out_in,
    // Pod drive of the wire
    output logic drive_out,
    output logic level_out
);
    int ts = 1;
    int oe_n = 0;
    int low_n = 0;
    int high_n = 0;

    // ------------------------------------------------------------
    // Device drive counters
    // ------------------------------------------------------------
    // Counted on every rising edge, so each device tick is seen once only at full rate; a divided tick is counted twice.
    always @(posedge clock_in) begin
        if (dev_oe_in === 1'b1) begin
            oe_n++;
            if (dev_out_in === 1'b0) low_n++;
            else high_n++;
        end
    end

    initial begin
        drive_out = 1'b0;
        level_out = 1'b1;
    end

    // Waits a number of debug ticks on falling clock edges.
    task automatic wt(input int n);
        repeat (n * ts) @(negedge clock_in);
    endtask

    // Sends the top bits of a byte; eighteen ticks keep bits apart.
    task automatic send_byte(input logic [7:0] d, input int nbits, output int oe_sum);
        oe_sum = 0;
        for (int i = 7; i > 7 - nbits; i--) begin
            oe_n = 0;
            drive_out = 1'b1;
            level_out = 1'b0;
            wt(4);
            level_out = d[i];
            wt(10);
            level_out = 1'b1;
            wt(4);
            oe_sum += oe_n;
        end
        drive_out = 1'b0;
    endtask

    // Reads a byte; the low pulse is short so the speedup never collides.
    task automatic recv_byte(output logic [7:0] d, output int bad);
        bad = 0;
        for (int i = 7; i >= 0; i--) begin
            low_n = 0;
            high_n = 0;
            drive_out = 1'b1;
            level_out = 1'b0;
            wt(3);
            drive_out = 1'b0;
            wt(7);
            d[i] = wire_in;
            wt(8);
            if (ts == 1 && (low_n != (d[i] ? 0 : 13) || high_n != 1)) bad++;
        end
    endtask

    // Long low request, then the device's low time is measured.
    task automatic rate_req(output int lows);
        drive_out = 1'b1;
        level_out = 1'b0;
        repeat (140) @(negedge clock_in);
        drive_out = 1'b0;
        low_n = 0;
        repeat (200) @(negedge clock_in);
        lows = low_n;
    endtask

    // Holds the wire low, used around a reset.
    task automatic hold(input logic on);
        drive_out = on;
        level_out = 1'b0;
    endtask

    // Delay slot before a reply.
    task automatic gap();
        wt(16);
    endtask
endmodule // host_pod

// *** verification/debug_wire_link_test.sv ***
/*
 * Self-checking bench of the debug wire link with a pod model.
 * Assumes the package and constants header are compiled beforehand.
 */
`timescale 1ns/1ps
module debug_wire_link_test;
    import dbg_link_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, clk_sel = 1'b0, alt_tick = 1'b0;
    logic halted = 1'b0, cmd_done = 1'b0, tx_valid = 1'b0;
    byte_t tx_data = 8'h00;
    byte_t rx_data, rx_last;
    logic pin_out, pin_oe, rx_valid, rx_cmd, tx_ready, cmd_reject, abort_p;
    logic sync_done, boot_halt, pod_drive, pod_level, rx_cmd_last;
    logic pin_wire;
    int n_errors = 0, n_checks = 0, cyc = 0, rx_n = 0, rej_n = 0, abort_n = 0, sync_n = 0;

    // The device wins while enabled; else the pod; else the pull-up.
    assign pin_wire = pin_oe ? pin_out : (pod_drive ? pod_level : 1'b1);

    debug_wire_link DUT (.CLOCK_IN(clock), .RESETN_IN(resetn), .DBG_CLK_SEL_IN(clk_sel),
        .ALT_TICK_IN(alt_tick), .PIN_IN(pin_wire), .PIN_OUT_OUT(pin_out),
        .PIN_OE_OUT(pin_oe), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid),
        .RX_CMD_OUT(rx_cmd), .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid),
        .TX_READY_OUT(tx_ready), .HALTED_IN(halted), .CMD_DONE_IN(cmd_done),
        .CMD_REJECT_OUT(cmd_reject), .ABORT_OUT(abort_p), .SYNC_DONE_OUT(sync_done),
        .BOOT_HALT_OUT(boot_halt));
    host_pod pod (.clock_in(clock), .wire_in(pin_wire), .dev_oe_in(pin_oe),
        .dev_out_in(pin_out), .drive_out(pod_drive), .level_out(pod_level));

    // ------------------------------------------------------------
    // Clocks, pulse monitors and hang guard
    // ------------------------------------------------------------
    always #2 clock = ~clock;
    // Alternate tick every other cycle, so the divided mode runs at half rate.
    always @(negedge clock) alt_tick <= ~alt_tick;
    always @(posedge clock) begin
        cyc++;
        if (rx_valid === 1'b1) begin
            rx_n++;
            rx_last = rx_data;
            rx_cmd_last = rx_cmd;
        end
        if (cmd_reject === 1'b1) rej_n++;
        if (abort_p === 1'b1) abort_n++;
        if (sync_done === 1'b1) sync_n++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("COUNTS checks=%0d mismatches=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // Shared drivers
    // ------------------------------------------------------------
    task automatic send_cmd(input byte_t b);
        int oe;
        pod.send_byte(b, 8, oe);
        // At the divided rate the byte pulse lands up to five cycles after the last bit.
        repeat (2 * pod.ts + 1) @(negedge clock);
        check(16'(oe), 16'h0000);
    endtask

    task automatic frame_end();
        @(negedge clock) cmd_done = 1'b1;
        @(negedge clock) cmd_done = 1'b0;
    endtask

    // Ready is looked at on the falling edge, so the next rising edge takes the byte.
    task automatic push(input byte_t b);
        int k;
        @(negedge clock);
        tx_data = b;
        tx_valid = 1'b1;
        k = 0;
        while (tx_ready !== 1'b1 && k < 50) begin
            @(negedge clock);
            k++;
        end
        @(negedge clock);
        tx_valid = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_host();
        int r0;
        halted = 1'b1;
        r0 = rx_n;
        send_cmd(8'h68);
        check({8'h00, rx_last}, 16'h0068);
        check(16'(rx_cmd_last), 16'h0001);
        send_cmd(8'h3c);
        check({8'h00, rx_last}, 16'h003c);
        check(16'(rx_cmd_last), 16'h0000);
        check(16'(rx_n - r0), 16'h0002);
        frame_end();
        $display("TEST host bytes done");
    endtask

    task automatic t_codes();
        byte_t codes [5] = '{8'he0, 8'h90, 8'hd5, 8'hd6, 8'hc4};
        int r0, x0;
        halted = 1'b0;
        r0 = rej_n;
        x0 = rx_n;
        send_cmd(8'h08);
        check(16'(rej_n - r0), 16'h0001);
        check(16'(rx_n - x0), 16'h0000);
        foreach (codes[i]) begin
            send_cmd(codes[i]);
            check({8'h00, rx_last}, {8'h00, codes[i]});
            check(16'(rx_cmd_last), 16'h0001);
            frame_end();
        end
        $display("TEST command classes done");
    endtask

    task automatic t_reply();
        logic [7:0] d;
        int bad;
        halted = 1'b1;
        send_cmd(8'he4);
        pod.gap();
        push(8'ha5);
        push(8'h5a);
        check(16'(tx_ready), 16'h0000); // Two bytes waiting fill the buffer.
        pod.recv_byte(d, bad);
        check({8'h00, d}, 16'h00a5);
        check(16'(bad), 16'h0000);
        pod.recv_byte(d, bad);
        check({8'h00, d}, 16'h005a);
        check(16'(bad), 16'h0000);
        check(16'(tx_ready), 16'h0001); // The drained buffer takes bytes again.
        frame_end();
        $display("TEST reply bytes done");
    endtask

    task automatic t_sync();
        int lows, s0;
        s0 = sync_n;
        pod.rate_req(lows);
        check(16'(lows), 16'h0080);
        check(16'(sync_n - s0), 16'h0001);
        frame_end();
        $display("TEST rate pulse done");
    endtask

    task automatic t_timeout();
        int oe, a0;
        a0 = abort_n;
        pod.send_byte(8'hf0, 4, oe);
        push(8'h11);
        push(8'h22);
        repeat (380) @(negedge clock);
        check(16'(abort_n - a0), 16'h0000);
        repeat (200) @(negedge clock);
        check(16'(abort_n - a0), 16'h0001);
        check(16'(tx_ready), 16'h0001);
        send_cmd(8'he0);
        check({8'h00, rx_last}, 16'h00e0);
        check(16'(rx_cmd_last), 16'h0001);
        frame_end();
        $display("TEST timeout done");
    endtask

    task automatic t_alt();
        clk_sel = 1'b1;
        pod.ts = 2;
        send_cmd(8'hc4);
        check({8'h00, rx_last}, 16'h00c4);
        pod.ts = 1;
        clk_sel = 1'b0;
        frame_end();
        $display("TEST alternate clock done");
    endtask

    // Last on purpose: releasing the held pin may leave a stray bit behind.
    task automatic t_boot();
        pod.hold(1'b1);
        @(negedge clock) resetn = 1'b0;
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        pod.hold(1'b0);
        repeat (2) @(negedge clock);
        check(16'(boot_halt), 16'h0001);
        $display("TEST boot mode done");
    endtask

    initial begin
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
        check(16'(boot_halt), 16'h0000);
        check(16'(tx_ready), 16'h0001); // The buffer leaves reset empty.
        check(16'(pin_oe), 16'h0000);
        $display("TEST reset done");
        t_host();
        t_codes();
        t_reply();
        t_sync();
        t_timeout();
        t_alt();
        t_boot();
        stop_test();
    end
endmodule // debug_wire_link_test
